//--- verilog/usart_channel.sv
// Serial channel: bit-rate generator, framing engine, test modes and Avalon-MM registers
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
// What this block does
// - Bit-rate tick feeds both receiver and transmitter
// - Source: master clock, master/8, or pin
// - Sixteen-bit programmable divider from baud_divisor
// - Divisor zero stops output ticks, except in sync mode on the pin clock
// - Divisor one passes source ticks undivided
// - Async: divided tick samples, then /16 or /8
// - Oversample bit one gives x8, else x16
// - Async rate is source/(8(2-over)divisor)
// - Five to nine data bits, 1/1.5/2 stops
// - Even/odd/mark/space/no parity, MSB or LSB first
// - Flag parity, framing and overrun errors
// - Multi-drop address marker sent and detected
// - RTS and CTS handled by hardware
// - Remote loopback, local loopback, automatic echo
// - Missing modem pins make modem bits inert
// - Config writes accepted while engine clock gated
// - Gated engine resumes exactly where stopped
module usart_channel
    import usart_pkg::*;
#(
    parameter int HAS_MODEM = 1,
    parameter int PRE_DIV = PRESCALE_DIV
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic rxd_in,
    input wire logic sck_in,
    input wire logic cts_b_in,
    input wire logic dsr_b_in,
    input wire logic dcd_b_in,
    input wire logic ri_b_in,
    output logic txd_out,
    output logic rts_b_out,
    output logic dtr_b_out
);
    // Position of data bit number idx within the character, honouring bit order
    function automatic logic [3:0] bit_pos(input logic [3:0] nbits, input logic [3:0] idx,
                                           input logic msbf);
        bit_pos = msbf ? 4'(nbits - 4'h1 - idx) : idx;
    endfunction

    function automatic logic par_calc(input logic [8:0] data, input logic [3:0] nbits,
                                      input logic [2:0] par, input logic addr);
        logic [8:0] mask;
        mask = 9'h1FF >> (4'h9 - nbits);
        case (par)
            PAR_EVEN: par_calc = ^(data & mask);
            PAR_ODD: par_calc = ~^(data & mask);
            PAR_SPACE: par_calc = 1'b0;
            PAR_MARK: par_calc = 1'b1;
            default: par_calc = addr;
        endcase
    endfunction

    logic [1:0] rst_s_q;
    logic rst_sync_b;
    logic [4:0] pin_meta_q;
    logic [4:0] pin_s_q;
    logic sck_d_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic [MODE_W-1:0] mode_q;
    logic [15:0] div_q;
    logic rx_en_q;
    logic tx_en_q;
    logic dtr_q;
    logic acc, wr_ctrl, rd_rxh, wr_txh;
    logic [31:0] status;
    logic [31:0] rd_mux;
    logic [7:0] pre_cnt_q;
    logic [15:0] div_cnt_q;
    logic src_tick, samp_tick;
    logic [4:0] bit_len, half_m1;
    logic [5:0] stop_len;
    logic [3:0] nbits;
    logic [2:0] par_mode;
    logic par_on, multidrop, rx_line, cts_ok;
    frame_state_t tx_st_q, rx_st_q;
    logic [5:0] tx_cnt_q;
    logic [4:0] rx_cnt_q;
    logic [3:0] tx_idx_q, rx_idx_q;
    logic [8:0] thr_q, tx_sh_q, rx_sh_q, rhr_q;
    logic thr_full_q, addr_pend_q, tx_addr_q, tx_line_q;
    logic rx_rdy_q, ovre_q, frame_q, pare_q, rx_addr_q, rx_par_q;
    logic rx_done;

    // Reset release through two flops
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_s_q <= 2'b00;
        end else begin
            rst_s_q <= {rst_s_q[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_s_q[1];

    // Pin synchronisers: rxd, sck, cts, dsr/dcd/ri packed as one vector
    always_ff @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pin_meta_q <= 5'h1F;
            pin_s_q <= 5'h1F;
            sck_d_q <= 1'b1;
        end else begin
            pin_meta_q <= {ri_b_in & dcd_b_in & dsr_b_in, cts_b_in, sck_in, rxd_in, 1'b1};
            pin_s_q <= pin_meta_q;
            sck_d_q <= pin_s_q[2];
        end
    end

    // Avalon slave: every request waits exactly one cycle, then completes
    assign acc = (avs_read_in | avs_write_in) & ~wait_q;
    assign wr_ctrl = acc & avs_write_in & (avs_address_in == OFS_CTRL);
    assign wr_txh = acc & avs_write_in & (avs_address_in == OFS_TXH);
    assign rd_rxh = acc & avs_read_in & (avs_address_in == OFS_RXH);

    always_comb begin
        status = 32'h00000000;
        status[SB_RXRDY] = rx_rdy_q;
        status[SB_TXRDY] = tx_en_q & ~thr_full_q;
        status[SB_OVRE] = ovre_q;
        status[SB_FRAME] = frame_q;
        status[SB_PARE] = pare_q;
        status[SB_TXEMPTY] = tx_en_q & ~thr_full_q & (tx_st_q == S_IDLE);
        status[SB_RXADDR] = rx_addr_q;
        status[SB_CTS] = ~pin_s_q[3];
        // Modem status reads zero on instances without those pins
        status[SB_RI] = (HAS_MODEM != 0) & ~pin_s_q[4];
        status[SB_DSR] = (HAS_MODEM != 0) & ~pin_s_q[4];
        status[SB_DCD] = (HAS_MODEM != 0) & ~pin_s_q[4];
        case (avs_address_in)
            OFS_MODE: rd_mux = {{(32 - MODE_W){1'b0}}, mode_q};
            OFS_BRG: rd_mux = {16'h0000, div_q};
            OFS_STAT: rd_mux = status;
            OFS_RXH: rd_mux = {23'h000000, rhr_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q <= ~((avs_read_in | avs_write_in) & wait_q);
            if ((avs_read_in | avs_write_in) & wait_q) begin
                rdata_q <= rd_mux;
            end
        end
    end
    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = wait_q;

    // Configuration is written on the bus clock, not the gated engine enable
    always_ff @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mode_q <= MODE_RST;
            div_q <= DIV_RST;
        end else if (acc & avs_write_in) begin
            if (avs_address_in == OFS_MODE) begin
                mode_q <= avs_writedata_in[MODE_W-1:0];
            end
            if (avs_address_in == OFS_BRG) begin
                div_q <= avs_writedata_in[15:0];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rx_en_q <= 1'b0;
            tx_en_q <= 1'b0;
            dtr_q <= 1'b0;
        end else if (wr_ctrl) begin
            // Disable wins when both bits are written together
            if (avs_writedata_in[CB_RXDIS] | avs_writedata_in[CB_RSTRX]) begin
                rx_en_q <= 1'b0;
            end else if (avs_writedata_in[CB_RXEN]) begin
                rx_en_q <= 1'b1;
            end
            if (avs_writedata_in[CB_TXDIS] | avs_writedata_in[CB_RSTTX]) begin
                tx_en_q <= 1'b0;
            end else if (avs_writedata_in[CB_TXEN]) begin
                tx_en_q <= 1'b1;
            end
            if (avs_writedata_in[CB_DTRDIS]) begin
                dtr_q <= 1'b0;
            end else if (avs_writedata_in[CB_DTREN]) begin
                dtr_q <= 1'b1;
            end
        end
    end

    // Mode decode
    assign nbits = mode_q[MB_MODE9] ? 4'h9 : 4'(mode_q[MB_CHRL+:2] + 2'h1) + 4'h4;
    assign par_mode = mode_q[MB_PAR+:3];
    assign par_on = (par_mode[2:1] != 2'b10);
    assign multidrop = (par_mode[2:1] == 2'b11);
    assign bit_len = mode_q[MB_SYNC] ? 5'h01 : (mode_q[MB_OVER] ? OVS_BY8 : OVS_BY16);
    assign half_m1 = (bit_len == 5'h01) ? 5'h00 : 5'((bit_len >> 1) - 5'h01);
    always_comb begin
        case (mode_q[MB_STOP+:2])
            STOP_ONE_HALF: stop_len = 6'(bit_len) + 6'(bit_len >> 1);
            STOP_TWO: stop_len = 6'(bit_len) << 1;
            default: stop_len = 6'(bit_len);
        endcase
    end

    // Source selection; the engine only advances while clk_en_in is high
    always_comb begin
        case (mode_q[MB_CLKSEL+:2])
            CLK_DIVIDED: src_tick = clk_en_in & (pre_cnt_q == 8'(PRE_DIV - 1));
            CLK_EXTERNAL: src_tick = clk_en_in & pin_s_q[2] & ~sck_d_q;
            default: src_tick = clk_en_in;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pre_cnt_q <= 8'h00;
            div_cnt_q <= 16'h0000;
        end else if (clk_en_in) begin
            pre_cnt_q <= (pre_cnt_q == 8'(PRE_DIV - 1)) ? 8'h00 : pre_cnt_q + 8'h01;
            if (src_tick) begin
                div_cnt_q <= (div_cnt_q >= div_q - 16'h0001) ? 16'h0000 : div_cnt_q + 16'h0001;
            end
        end
    end

    // Sync mode with pin clock ignores the divisor; zero divisor yields nothing
    always_comb begin
        if (mode_q[MB_SYNC] && mode_q[MB_CLKSEL+:2] == CLK_EXTERNAL) begin
            samp_tick = src_tick;
        end else if (div_q == 16'h0000) begin
            samp_tick = 1'b0;
        end else if (div_q == 16'h0001) begin
            samp_tick = src_tick;
        end else begin
            samp_tick = src_tick & (div_cnt_q >= div_q - 16'h0001);
        end
    end

    // Flow control: a held-off CTS delays the next character, never cuts one short
    assign cts_ok = ~mode_q[MB_FLOW] | ~pin_s_q[3];

    // Transmitter: one bit lasts bit_len sample ticks
    always_ff @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tx_st_q <= S_IDLE;
            tx_cnt_q <= 6'h00;
            tx_idx_q <= 4'h0;
            thr_q <= 9'h000;
            tx_sh_q <= 9'h000;
            thr_full_q <= 1'b0;
            addr_pend_q <= 1'b0;
            tx_addr_q <= 1'b0;
            tx_line_q <= 1'b1;
        end else if (wr_ctrl & avs_writedata_in[CB_RSTTX]) begin
            tx_st_q <= S_IDLE;
            thr_full_q <= 1'b0;
            addr_pend_q <= 1'b0;
            tx_line_q <= 1'b1;
        end else begin
            if (wr_ctrl & avs_writedata_in[CB_SENDADDR]) begin
                addr_pend_q <= 1'b1;
            end
            // A write while the holding register is full is dropped
            if (wr_txh & tx_en_q & ~thr_full_q) begin
                thr_q <= avs_writedata_in[8:0];
                thr_full_q <= 1'b1;
            end
            if (samp_tick) begin
                case (tx_st_q)
                    S_IDLE: begin
                        if (thr_full_q & cts_ok) begin
                            tx_sh_q <= thr_q;
                            tx_addr_q <= addr_pend_q;
                            // A send-address command in the load cycle marks the next character
                            addr_pend_q <= wr_ctrl & avs_writedata_in[CB_SENDADDR];
                            thr_full_q <= 1'b0;
                            tx_line_q <= 1'b0;
                            tx_cnt_q <= 6'h00;
                            tx_st_q <= S_START;
                        end
                    end
                    S_START, S_DATA, S_PAR: begin
                        if (tx_cnt_q == 6'(bit_len - 5'h01)) begin
                            tx_cnt_q <= 6'h00;
                            if (tx_st_q == S_START) begin
                                tx_idx_q <= 4'h1;
                                tx_line_q <= tx_sh_q[bit_pos(nbits, 4'h0, mode_q[MB_MSBF])];
                                tx_st_q <= S_DATA;
                            end else if (tx_st_q == S_DATA && tx_idx_q != nbits) begin
                                tx_idx_q <= tx_idx_q + 4'h1;
                                tx_line_q <= tx_sh_q[bit_pos(nbits, tx_idx_q, mode_q[MB_MSBF])];
                            end else if (tx_st_q == S_DATA && par_on) begin
                                tx_line_q <= par_calc(tx_sh_q, nbits, par_mode, tx_addr_q);
                                tx_st_q <= S_PAR;
                            end else begin
                                tx_line_q <= 1'b1;
                                tx_st_q <= S_STOP;
                            end
                        end else begin
                            tx_cnt_q <= tx_cnt_q + 6'h01;
                        end
                    end
                    S_STOP: begin
                        if (tx_cnt_q == stop_len - 6'h01) begin
                            tx_cnt_q <= 6'h00;
                            tx_st_q <= S_IDLE;
                        end else begin
                            tx_cnt_q <= tx_cnt_q + 6'h01;
                        end
                    end
                    default: tx_st_q <= S_IDLE;
                endcase
            end
        end
    end

    // Receiver input per test mode; remote loopback disconnects the receiver
    always_comb begin
        case (mode_q[MB_CHMODE+:2])
            CHM_LOCAL: rx_line = tx_line_q;
            CHM_REMOTE: rx_line = 1'b1;
            default: rx_line = pin_s_q[1];
        endcase
    end

    assign rx_done = samp_tick & (rx_st_q == S_STOP) & (rx_cnt_q == bit_len - 5'h01);

    // Receiver: start confirmed at mid bit, then one sample per bit
    always_ff @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rx_st_q <= S_IDLE;
            rx_cnt_q <= 5'h00;
            rx_idx_q <= 4'h0;
            rx_sh_q <= 9'h000;
            rx_par_q <= 1'b0;
        end else if (wr_ctrl & avs_writedata_in[CB_RSTRX]) begin
            rx_st_q <= S_IDLE;
        end else if (samp_tick) begin
            case (rx_st_q)
                S_IDLE: begin
                    if (rx_en_q & ~rx_line) begin
                        rx_cnt_q <= 5'h00;
                        rx_sh_q <= 9'h000;
                        rx_idx_q <= 4'h0;
                        rx_st_q <= S_START;
                    end
                end
                S_START: begin
                    if (rx_cnt_q == half_m1) begin
                        rx_cnt_q <= 5'h00;
                        rx_st_q <= rx_line ? S_IDLE : S_DATA;
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 5'h01;
                    end
                end
                S_DATA, S_PAR, S_STOP: begin
                    if (rx_cnt_q == bit_len - 5'h01) begin
                        rx_cnt_q <= 5'h00;
                        if (rx_st_q == S_DATA) begin
                            rx_sh_q[bit_pos(nbits, rx_idx_q, mode_q[MB_MSBF])] <= rx_line;
                            rx_idx_q <= rx_idx_q + 4'h1;
                            if (rx_idx_q == nbits - 4'h1) begin
                                rx_st_q <= par_on ? S_PAR : S_STOP;
                            end
                        end else if (rx_st_q == S_PAR) begin
                            rx_par_q <= rx_line;
                            rx_st_q <= S_STOP;
                        end else begin
                            rx_st_q <= S_IDLE;
                        end
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 5'h01;
                    end
                end
                default: rx_st_q <= S_IDLE;
            endcase
        end
    end

    // Receive status: a new event in the clearing cycle keeps its flag set
    always_ff @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rhr_q <= 9'h000;
            rx_rdy_q <= 1'b0;
            ovre_q <= 1'b0;
            frame_q <= 1'b0;
            pare_q <= 1'b0;
            rx_addr_q <= 1'b0;
        end else begin
            if (rx_done) begin
                rhr_q <= rx_sh_q;
                rx_rdy_q <= 1'b1;
            end else if (rd_rxh | (wr_ctrl & avs_writedata_in[CB_RSTRX])) begin
                rx_rdy_q <= 1'b0;
            end
            if (wr_ctrl & avs_writedata_in[CB_RSTSTA]) begin
                ovre_q <= 1'b0;
                frame_q <= 1'b0;
                pare_q <= 1'b0;
                rx_addr_q <= 1'b0;
            end
            if (rx_done & rx_rdy_q & ~rd_rxh) begin
                ovre_q <= 1'b1;
            end
            if (rx_done & ~rx_line) begin
                frame_q <= 1'b1;
            end
            if (rx_done & par_on & ~multidrop &
                (rx_par_q != par_calc(rx_sh_q, nbits, par_mode, 1'b0))) begin
                pare_q <= 1'b1;
            end
            if (rx_done & multidrop & rx_par_q) begin
                rx_addr_q <= 1'b1;
            end
        end
    end

    // Output pins, each from a flop
    always_ff @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            txd_out <= 1'b1;
            rts_b_out <= 1'b1;
            dtr_b_out <= 1'b1;
        end else begin
            case (mode_q[MB_CHMODE+:2])
                CHM_ECHO, CHM_REMOTE: txd_out <= pin_s_q[1];
                CHM_LOCAL: txd_out <= 1'b1;
                default: txd_out <= tx_line_q;
            endcase
            // Deasserted while a character waits unread, so the far end holds off
            rts_b_out <= mode_q[MB_FLOW] ? ~(rx_en_q & ~rx_rdy_q) : 1'b0;
            dtr_b_out <= (HAS_MODEM != 0) ? ~dtr_q : 1'b1;
        end
    end
endmodule

//--- verilog/usart_pkg.sv
// Register map, field layout, encodings and state types of the serial channel
package usart_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_MODE = 5'h04;
    localparam logic [4:0] OFS_BRG = 5'h08;
    localparam logic [4:0] OFS_STAT = 5'h0C;
    localparam logic [4:0] OFS_TXH = 5'h10;
    localparam logic [4:0] OFS_RXH = 5'h14;
    // Command bits of the control register (write-only, write 1 to act)
    localparam int CB_RSTRX = 0;
    localparam int CB_RSTTX = 1;
    localparam int CB_RXEN = 2;
    localparam int CB_RXDIS = 3;
    localparam int CB_TXEN = 4;
    localparam int CB_TXDIS = 5;
    localparam int CB_RSTSTA = 6;
    localparam int CB_SENDADDR = 7;
    localparam int CB_DTREN = 8;
    localparam int CB_DTRDIS = 9;
    // Fields of channel_mode_config
    localparam int MB_FLOW = 0;
    localparam int MB_CLKSEL = 4;
    localparam int MB_CHRL = 6;
    localparam int MB_SYNC = 8;
    localparam int MB_PAR = 9;
    localparam int MB_STOP = 12;
    localparam int MB_CHMODE = 14;
    localparam int MB_MSBF = 16;
    localparam int MB_MODE9 = 17;
    localparam int MB_OVER = 19;
    localparam int MODE_W = 20;
    localparam logic [19:0] MODE_RST = 20'h00000;
    localparam logic [15:0] DIV_RST = 16'h0000;
    // Status register bits
    localparam int SB_RXRDY = 0;
    localparam int SB_TXRDY = 1;
    localparam int SB_OVRE = 5;
    localparam int SB_FRAME = 6;
    localparam int SB_PARE = 7;
    localparam int SB_TXEMPTY = 9;
    localparam int SB_RXADDR = 10;
    localparam int SB_RI = 16;
    localparam int SB_DSR = 17;
    localparam int SB_DCD = 18;
    localparam int SB_CTS = 19;
    // Encodings
    localparam logic [1:0] CLK_MASTER = 2'h0;
    localparam logic [1:0] CLK_DIVIDED = 2'h1;
    localparam logic [1:0] CLK_EXTERNAL = 2'h3;
    localparam logic [2:0] PAR_EVEN = 3'h0;
    localparam logic [2:0] PAR_ODD = 3'h1;
    localparam logic [2:0] PAR_SPACE = 3'h2;
    localparam logic [2:0] PAR_MARK = 3'h3;
    localparam logic [1:0] CHM_NORMAL = 2'h0;
    localparam logic [1:0] CHM_ECHO = 2'h1;
    localparam logic [1:0] CHM_LOCAL = 2'h2;
    localparam logic [1:0] CHM_REMOTE = 2'h3;
    localparam logic [1:0] STOP_ONE_HALF = 2'h1;
    localparam logic [1:0] STOP_TWO = 2'h2;
    localparam int PRESCALE_DIV = 8;
    localparam logic [4:0] OVS_BY16 = 5'h10;
    localparam logic [4:0] OVS_BY8 = 5'h08;
    typedef enum logic [4:0] {
        S_IDLE = 5'h01, S_START = 5'h02, S_DATA = 5'h04, S_PAR = 5'h08, S_STOP = 5'h10
    } frame_state_t;
endpackage

//--- verif/usart_channel_properties.sv
// Port-level checker for the serial channel
`timescale 1ns/10ps
module usart_channel_chk
    import usart_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic cts_b_in,
    input wire logic txd_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_stat_rd;
        avs_read_in && avs_waitrequest_out && avs_address_in == OFS_STAT;
    endsequence
    chk_wait_answer: assert property (s_req |=> !avs_waitrequest_out)
        else $error("bus request not answered");
    chk_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    chk_wait_idle: assert property (!(avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> avs_waitrequest_out) else $error("answer without request");
    chk_read_stands: assert property (avs_waitrequest_out && !avs_read_in && !avs_write_in
        |=> $stable(avs_readdata_out)) else $error("read data moved while idle");
    chk_gate_freeze: assert property (!clk_en_in && !$past(clk_en_in) && !$past(clk_en_in, 2)
        |-> $stable(txd_out)) else $error("line moved while gated");
    chk_bit_min: assert property ($changed(txd_out) |=> $stable(txd_out)[*7])
        else $error("bit shorter than eight clocks");
    chk_cts_status: assert property ($stable(cts_b_in)[*4] ##0 s_stat_rd
        |=> avs_readdata_out[SB_CTS] == !cts_b_in) else $error("clear to send status wrong");
    chk_reset_quiet: assert property ($rose(rst_b_in) |-> txd_out[*8])
        else $error("line active after reset");
endmodule
bind usart_channel usart_channel_chk i_chk (.clk_in, .rst_b_in, .clk_en_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .cts_b_in, .txd_out);

//--- verif/serial_far_end.sv
// Far-end serial device: echoes the line back and keeps modem lines quiet
`timescale 1ns/10ps
module serial_far_end (
    input wire logic txd_in,
    output logic rxd_out,
    output logic sck_out,
    output logic cts_b_out,
    output logic dsr_b_out,
    output logic dcd_b_out,
    output logic ri_b_out
);
    // Echo lets one frame load both directions from the same tick
    assign rxd_out = txd_in;
    // Free-running pin clock of 20 master periods: long phases, far below master/4.5
    always #250 sck_out = (sck_out !== 1'b1);
    assign cts_b_out = 1'b0;
    assign dsr_b_out = 1'b1;
    assign dcd_b_out = 1'b1;
    assign ri_b_out = 1'b1;
endmodule

//--- verif/test_usart_channel.sv
// Self-checking bench for the serial channel
`timescale 1ns/10ps
`define CHECK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected %s exp %h got %h", what, exp, got); end end
module test_usart_channel;
    import usart_pkg::*;
    logic clk_in = 0, rst_b_in = 0, clk_en_in = 1, avs_read_in = 0, avs_write_in = 0;
    logic [4:0] avs_address_in = 5'h00;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
    logic avs_waitrequest_out, rxd_in, sck_in, cts_b_in, dsr_b_in, dcd_b_in, ri_b_in;
    logic txd_out, rts_b_out, dtr_b_out;
    int n_errors = 0, total_checks = 0;
    // Rates picked for exact division, well inside the error budget
    localparam logic [19:0] MODES [10] = '{20'h808C0, 20'h008C0, 20'h808C0, 20'h808D0,
        20'h808F0, 20'h800C0, 20'h802C0, 20'h804C0, 20'h806C0, 20'h912C0};
    localparam logic [15:0] DIVS [10] = '{16'h1, 16'h1, 16'h3, 16'h1, 16'h1, 16'h1, 16'h1,
        16'h1, 16'h1, 16'h1};
    localparam int LENS [10] = '{8, 16, 24, 64, 160, 8, 8, 8, 8, 8};
    localparam logic [10:0] LINES [10] = '{11'h262, 11'h262, 11'h262, 11'h262, 11'h262,
        11'h662, 11'h462, 11'h462, 11'h662, 11'h518};
    always #12.5 clk_in = ~clk_in;
    usart_channel i_usart_channel (.clk_in, .rst_b_in, .clk_en_in, .avs_address_in,
        .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
        .avs_waitrequest_out, .rxd_in, .sck_in, .cts_b_in, .dsr_b_in, .dcd_b_in, .ri_b_in,
        .txd_out, .rts_b_out, .dtr_b_out);
    serial_far_end i_serial_far_end (.txd_in(txd_out), .rxd_out(rxd_in), .sck_out(sck_in),
        .cts_b_out(cts_b_in), .dsr_b_out(dsr_b_in), .dcd_b_out(dcd_b_in), .ri_b_out(ri_b_in));
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        @(posedge clk_in);
        while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic test_regs();
        bus(0, OFS_MODE, 32'h0);
        `CHECK("mode reset", {12'h000, MODE_RST}, rd)
        bus(0, OFS_BRG, 32'h0);
        `CHECK("divisor reset", {16'h0000, DIV_RST}, rd)
        bus(1, OFS_BRG, 32'hFFFFFFFF);
        bus(0, OFS_BRG, 32'h0);
        `CHECK("divisor width", 32'h0000FFFF, rd)
        bus(0, 5'h18, 32'h0);
        `CHECK("unmapped read", 32'h0, rd)
        `CHECK("rts without flow", 1'b0, rts_b_out)
        `CHECK("dtr after reset", 1'b1, dtr_b_out)
        bus(1, OFS_CTRL, 32'h100);
        @(posedge clk_in);
        `CHECK("dtr on", 1'b0, dtr_b_out)
        $display("test regs done");
    endtask
    task automatic test_no_tick();
        bus(1, OFS_BRG, 32'h0);
        bus(1, OFS_CTRL, 32'h10);
        bus(1, OFS_TXH, 32'h31);
        repeat (200) begin
            @(posedge clk_in);
            `CHECK("idle line", 1'b1, txd_out)
        end
        $display("test no tick done");
    endtask
    // Send one character, sample mid-bit, then read it back from the echo
    task automatic frame(input int k);
        int i;
        bus(1, OFS_CTRL, 32'h3);
        bus(1, OFS_MODE, {12'h000, MODES[k]});
        bus(1, OFS_BRG, {16'h0000, DIVS[k]});
        bus(1, OFS_CTRL, 32'h14);
        bus(1, OFS_TXH, 32'h31);
        for (i = 0; i < 400 && txd_out !== 1'b0; i++) @(posedge clk_in);
        repeat (LENS[k] / 2) @(posedge clk_in);
        for (i = 0; i < (LINES[k][10] ? 11 : 10); i++) begin
            `CHECK("line bit", LINES[k][i], txd_out)
            if (k == 2 && i == 2) begin
                clk_en_in <= 1'b0;
                bus(1, OFS_BRG, 32'h5);
                bus(0, OFS_BRG, 32'h0);
                `CHECK("divisor while gated", 32'h5, rd)
                bus(1, OFS_BRG, {16'h0000, DIVS[k]});
                repeat (30) @(posedge clk_in);
                clk_en_in <= 1'b1;
            end
            repeat (LENS[k]) @(posedge clk_in);
        end
        repeat (8) @(posedge clk_in);
        bus(0, OFS_STAT, 32'h0);
        `CHECK("rx ready", 1'b1, rd[SB_RXRDY])
        `CHECK("rx errors", 3'h0, rd[7:5])
        bus(0, OFS_RXH, 32'h0);
        `CHECK("rx data", 9'h031, rd[8:0])
        $display("test frame %0d done", k);
    endtask
    task automatic test_overrun();
        bus(1, OFS_TXH, 32'h31);
        repeat (20) @(posedge clk_in);
        bus(1, OFS_TXH, 32'h31);
        repeat (300) @(posedge clk_in);
        bus(0, OFS_STAT, 32'h0);
        `CHECK("overrun flag", 1'b1, rd[SB_OVRE])
        bus(1, OFS_MODE, 32'h912C1);
        @(posedge clk_in);
        `CHECK("rts held off", 1'b1, rts_b_out)
        $display("test overrun done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        test_regs();
        test_no_tick();
        for (int k = 0; k < 10; k++) frame(k);
        test_overrun();
        give_verdict();
    end
endmodule
